// ---- hw/hir_report_regaccess.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hir_cfg.svh"
// Functional notes
// - Each request is answered by a 37-byte response whose first byte is 0x00.
// - A malformed request is not executed and response status bit 0 is set.
// - A byte not acknowledged by the target aborts the transfer and sets status bit 1.
// - Lost arbitration aborts the transfer and sets status bit 2.
// - Status bit 3 is set if the bus is not free within 256 ms or a byte takes over 10 ms.
// - Response flag bits 7 to 4 echo the sequence value of the request.
// - Response offsets 2 and 3 hold the bytes actually written and read, 0 to 32.
// - Response offset 4 is always 0x00.
// - Response data starts at offset 5, spans 32 bytes, and only read-count bytes are valid.
// - Feature report 0x3C of 5 bytes writes a 16-bit value to the given address.
// - Feature report 0x4B of 3 bytes latches the read pointer.
// - Feature report 0x5A returns the register at the read pointer, low byte first.
// - Every request is followed automatically by exactly one response.
// - Request flag bit 0 asks start, bit 1 stop, bit 2 acknowledges the last read byte.
// - The target address is the upper seven bits of offset 4 plus a direction bit.
module hir_report_regaccess #(
   parameter int unsigned FREE_CYC = `HIR_FREE_MS * `HIR_CLK_KHZ,
   parameter int unsigned BYTE_CYC = `HIR_BYTE_MS * `HIR_CLK_KHZ
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Request stream.
   input wire logic i_out_valid,
   input wire logic [7:0] i_out_byte,
   output logic o_out_ready,
   // Response stream.
   output logic o_in_valid,
   output logic [7:0] o_in_byte,
   output logic o_in_last,
   input wire logic i_in_ready,
   // Byte engine.
   output hir_pkg::hir_eng_cmd_t o_eng_cmd,
   input wire hir_pkg::hir_eng_rsp_t i_eng_rsp,
   input wire logic i_bus_free,
   // Feature reports.
   input wire logic i_feat_valid,
   input wire logic [7:0] i_feat_byte,
   input wire logic i_feat_end,
   input wire logic i_get_req,
   input wire logic [7:0] i_get_id,
   output logic o_get_valid,
   output logic [15:0] o_get_data,
   // Register contents.
   output hir_pkg::hir_regs_t o_regs
);
   localparam logic [24:0] FREE_LIM = 25'(FREE_CYC - 1);
   localparam logic [24:0] BYTE_LIM = 25'(BYTE_CYC - 1);

   // --------
   // Helpers.
   // --------
   function automatic hir_pkg::hir_state_t after_wr(input logic [7:0] fl,
      input logic [7:0] wc, input logic [7:0] rc);
      if (rc != 8'h00)
      begin
         after_wr = (fl[`HIR_FL_START] || wc != 8'h00) ? hir_pkg::ST_RADDR
                                                       : hir_pkg::ST_RBYTE;
      end
      else
      begin
         after_wr = fl[`HIR_FL_STOP] ? hir_pkg::ST_STOP : hir_pkg::ST_TX;
      end
   endfunction

   function automatic logic [4:0] reg_index(input logic [15:0] a);
      unique case (a)
         `HIR_A_SCL_LOW: reg_index = {1'b1, 4'd0};
         `HIR_A_SCL_HIGH: reg_index = {1'b1, 4'd1};
         `HIR_A_GPIO_DIR: reg_index = {1'b1, 4'd2};
         `HIR_A_GPIO_SET: reg_index = {1'b1, 4'd3};
         `HIR_A_GPIO_CLR: reg_index = {1'b1, 4'd4};
         `HIR_A_GPIO_LVL: reg_index = {1'b1, 4'd5};
         `HIR_A_GPIO_HIZ: reg_index = {1'b1, 4'd6};
         `HIR_A_GPIO_OD: reg_index = {1'b1, 4'd7};
         `HIR_A_GPIO_PU: reg_index = {1'b1, 4'd8};
         `HIR_A_GPIO_PD: reg_index = {1'b1, 4'd9};
         `HIR_A_GPIO_IRQM: reg_index = {1'b1, 4'd10};
         `HIR_A_GPIO_IRQR: reg_index = {1'b1, 4'd11};
         `HIR_A_PWMA_CTL: reg_index = {1'b1, 4'd12};
         `HIR_A_PWMA_HI: reg_index = {1'b1, 4'd13};
         `HIR_A_PWMA_LO: reg_index = {1'b1, 4'd14};
         `HIR_A_PWMB_CTL: reg_index = {1'b1, 4'd15};
         default: reg_index = 5'h00;
      endcase
   endfunction

   function automatic logic [15:0] wmask(input logic [3:0] ix);
      unique case (ix)
         4'd0, 4'd1: wmask = `HIR_M_FULL;
         4'd12, 4'd15: wmask = `HIR_M_PWM_CTL;
         4'd13, 4'd14: wmask = `HIR_M_PWM_TIME;
         default: wmask = `HIR_M_GPIO;
      endcase
   endfunction

   // --------
   // Request sequencer.
   // --------
   hir_pkg::hir_state_t st_q, st_d;
   logic [5:0] idx_q, idx_d, wi_q, wi_d, ri_q, ri_d;
   logic [7:0] rid_q, rid_d, fl_q, fl_d, wc_q, wc_d, rc_q, rc_d, ta_q, ta_d;
   logic [3:0] stat_q, stat_d;
   hir_pkg::hir_buf_t buf_q, buf_d;
   logic [24:0] tmr_q, tmr_d;
   hir_pkg::hir_eng_cmd_t cmd_q, cmd_d;
   logic rdy_q, rdy_d, iv_q, iv_d, il_q, il_d;
   logic [7:0] ib_q, ib_d;
   logic eng_st, done;

   always_comb
   begin
      st_d = st_q;
      idx_d = idx_q;
      wi_d = wi_q;
      ri_d = ri_q;
      rid_d = rid_q;
      fl_d = fl_q;
      wc_d = wc_q;
      rc_d = rc_q;
      ta_d = ta_q;
      stat_d = stat_q;
      buf_d = buf_q;
      eng_st = st_q inside {hir_pkg::ST_WADDR, hir_pkg::ST_WBYTE, hir_pkg::ST_RADDR,
                            hir_pkg::ST_RBYTE, hir_pkg::ST_STOP};
      done = eng_st && i_eng_rsp.done;
      if (done && i_eng_rsp.arb_lost)
      begin
         stat_d[`HIR_ST_ARB] = 1'b1;
         st_d = hir_pkg::ST_TX;
      end
      else if (done && i_eng_rsp.nak && st_q != hir_pkg::ST_RBYTE && st_q != hir_pkg::ST_STOP)
      begin
         stat_d[`HIR_ST_NAK] = 1'b1;
         st_d = hir_pkg::ST_STOP;
      end
      else if (eng_st && !done && tmr_q >= BYTE_LIM)
      begin
         stat_d[`HIR_ST_TMO] = 1'b1;
         st_d = hir_pkg::ST_TX;
      end
      else
      begin
         unique case (st_q)
            hir_pkg::ST_RX:
            begin
               if (i_out_valid && rdy_q)
               begin
                  unique case (idx_q)
                     6'd0: rid_d = i_out_byte;
                     `HIR_OFS_FLAGS: fl_d = i_out_byte;
                     `HIR_OFS_WCNT: wc_d = i_out_byte;
                     `HIR_OFS_RCNT: rc_d = i_out_byte;
                     `HIR_OFS_ADDR: ta_d = i_out_byte;
                     default: buf_d[5'(idx_q - `HIR_OFS_DATA)] = i_out_byte;
                  endcase
                  idx_d = (idx_q == `HIR_REP_LAST) ? 6'd0 : idx_q + 6'd1;
                  if (idx_q == `HIR_REP_LAST)
                  begin
                     st_d = hir_pkg::ST_CHECK;
                  end
               end
            end
            hir_pkg::ST_CHECK:
            begin
               stat_d = 4'h0;
               wi_d = 6'd0;
               ri_d = 6'd0;
               if (rid_q != `HIR_RID_IO || wc_q > `HIR_MAX_LEN || rc_q > `HIR_MAX_LEN)
               begin
                  stat_d[`HIR_ST_REQERR] = 1'b1;
                  st_d = hir_pkg::ST_TX;
               end
               else if (fl_q[`HIR_FL_START])
               begin
                  st_d = hir_pkg::ST_FREE;
               end
               else
               begin
                  st_d = (wc_q != 8'h00) ? hir_pkg::ST_WBYTE : after_wr(fl_q, wc_q, rc_q);
               end
            end
            hir_pkg::ST_FREE:
            begin
               if (i_bus_free)
               begin
                  st_d = (wc_q != 8'h00 || rc_q == 8'h00) ? hir_pkg::ST_WADDR
                                                          : hir_pkg::ST_RADDR;
               end
               else if (tmr_q >= FREE_LIM)
               begin
                  stat_d[`HIR_ST_TMO] = 1'b1;
                  st_d = hir_pkg::ST_TX;
               end
            end
            hir_pkg::ST_WADDR:
            begin
               if (done)
               begin
                  st_d = (wc_q != 8'h00) ? hir_pkg::ST_WBYTE : after_wr(fl_q, wc_q, rc_q);
               end
            end
            hir_pkg::ST_WBYTE:
            begin
               if (done)
               begin
                  wi_d = wi_q + 6'd1;
                  if ({2'b00, wi_d} == wc_q)
                  begin
                     st_d = after_wr(fl_q, wc_q, rc_q);
                  end
               end
            end
            hir_pkg::ST_RADDR:
            begin
               if (done)
               begin
                  st_d = hir_pkg::ST_RBYTE;
               end
            end
            hir_pkg::ST_RBYTE:
            begin
               if (done)
               begin
                  buf_d[ri_q[4:0]] = i_eng_rsp.rdata;
                  ri_d = ri_q + 6'd1;
                  if ({2'b00, ri_d} == rc_q)
                  begin
                     st_d = fl_q[`HIR_FL_STOP] ? hir_pkg::ST_STOP : hir_pkg::ST_TX;
                  end
               end
            end
            hir_pkg::ST_STOP:
            begin
               if (done)
               begin
                  st_d = hir_pkg::ST_TX;
               end
            end
            hir_pkg::ST_TX:
            begin
               if (iv_q && i_in_ready)
               begin
                  idx_d = idx_q + 6'd1;
                  if (idx_q == `HIR_REP_LAST)
                  begin
                     st_d = hir_pkg::ST_RX;
                     idx_d = 6'd0;
                  end
               end
            end
         endcase
      end
      if (st_d == hir_pkg::ST_TX && st_q != hir_pkg::ST_TX)
      begin
         idx_d = 6'd0;
      end
      tmr_d = (st_d != st_q || done) ? 25'd0 : tmr_q + 25'd1;
      rdy_d = st_d == hir_pkg::ST_RX;
      iv_d = st_d == hir_pkg::ST_TX;
      il_d = iv_d && idx_d == `HIR_REP_LAST;
      unique case (idx_d)
         6'd0: ib_d = `HIR_RID_IO;
         `HIR_OFS_FLAGS: ib_d = {fl_d[7:4], stat_d};
         `HIR_OFS_WCNT: ib_d = {2'b00, wi_d};
         `HIR_OFS_RCNT: ib_d = {2'b00, ri_d};
         `HIR_OFS_ADDR: ib_d = `HIR_RSVD_BYTE;
         default: ib_d = buf_d[5'(idx_d - `HIR_OFS_DATA)];
      endcase
      cmd_d.valid = st_d inside {hir_pkg::ST_WADDR, hir_pkg::ST_WBYTE, hir_pkg::ST_RADDR,
                                 hir_pkg::ST_RBYTE, hir_pkg::ST_STOP};
      cmd_d.ack = fl_d[`HIR_FL_ACKL] || ({2'b00, ri_d} != rc_d - 8'd1);
      cmd_d.data = 8'h00;
      unique case (st_d)
         hir_pkg::ST_WADDR:
         begin
            cmd_d.op = hir_pkg::OP_START_ADDR;
            cmd_d.data = {ta_d[7:1], 1'b0};
         end
         hir_pkg::ST_RADDR:
         begin
            cmd_d.op = hir_pkg::OP_START_ADDR;
            cmd_d.data = {ta_d[7:1], 1'b1};
         end
         hir_pkg::ST_WBYTE:
         begin
            cmd_d.op = hir_pkg::OP_WRITE;
            cmd_d.data = buf_d[wi_d[4:0]];
         end
         hir_pkg::ST_RBYTE: cmd_d.op = hir_pkg::OP_READ;
         hir_pkg::ST_STOP: cmd_d.op = hir_pkg::OP_STOP;
         default: cmd_d.op = hir_pkg::OP_NONE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_q <= hir_pkg::ST_RX;
         idx_q <= 6'd0;
         wi_q <= 6'd0;
         ri_q <= 6'd0;
         rid_q <= 8'h00;
         fl_q <= 8'h00;
         wc_q <= 8'h00;
         rc_q <= 8'h00;
         ta_q <= 8'h00;
         stat_q <= 4'h0;
         buf_q <= '0;
         tmr_q <= 25'd0;
         cmd_q <= '0;
         rdy_q <= 1'b0;
         iv_q <= 1'b0;
         il_q <= 1'b0;
         ib_q <= 8'h00;
      end
      else
      begin
         st_q <= st_d;
         idx_q <= idx_d;
         wi_q <= wi_d;
         ri_q <= ri_d;
         rid_q <= rid_d;
         fl_q <= fl_d;
         wc_q <= wc_d;
         rc_q <= rc_d;
         ta_q <= ta_d;
         stat_q <= stat_d;
         buf_q <= buf_d;
         tmr_q <= tmr_d;
         cmd_q <= cmd_d;
         rdy_q <= rdy_d;
         iv_q <= iv_d;
         il_q <= il_d;
         ib_q <= ib_d;
      end
   end

   // --------
   // Feature reports and register file.
   // --------
   logic [2:0] fc_q, fc_d;
   logic [4:0][7:0] fb_q, fb_d;
   logic [15:0] ptr_q, ptr_d, gd_q, gd_d;
   logic gv_q, gv_d;
   hir_pkg::hir_regs_t reg_q, reg_d;
   logic [4:0] wx, rx;
   logic [15:0] wd;

   always_comb
   begin
      fc_d = fc_q;
      fb_d = fb_q;
      ptr_d = ptr_q;
      reg_d = reg_q;
      wx = reg_index({fb_q[2], fb_q[1]});
      wd = {fb_q[4], fb_q[3]} & wmask(wx[3:0]);
      rx = reg_index(ptr_q);
      if (i_feat_valid && fc_q != 3'd7)
      begin
         if (fc_q <= 3'd4)
         begin
            fb_d[fc_q] = i_feat_byte;
         end
         fc_d = fc_q + 3'd1;
      end
      if (i_feat_end)
      begin
         fc_d = 3'd0;
         if (fb_q[0] == `HIR_RID_WR && fc_q == `HIR_LEN_WR && wx[4])
         begin
            unique case (wx[3:0])
               `HIR_IX_SET: reg_d[`HIR_IX_LVL] = reg_q[`HIR_IX_LVL] | wd;
               `HIR_IX_CLR: reg_d[`HIR_IX_LVL] = reg_q[`HIR_IX_LVL] & ~wd;
               default: reg_d[wx[3:0]] = wd;
            endcase
         end
         if (fb_q[0] == `HIR_RID_PTR && fc_q == `HIR_LEN_PTR)
         begin
            ptr_d = {fb_q[2], fb_q[1]};
         end
      end
      gv_d = i_get_req && i_get_id == `HIR_RID_RD;
      gd_d = gd_q;
      if (gv_d)
      begin
         gd_d = (rx[4] && rx[3:0] != `HIR_IX_SET && rx[3:0] != `HIR_IX_CLR)
                ? reg_q[rx[3:0]] : 16'h0000;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         fc_q <= 3'd0;
         fb_q <= '0;
         ptr_q <= 16'h0000;
         gd_q <= 16'h0000;
         gv_q <= 1'b0;
         reg_q <= '0;
         reg_q[`HIR_IX_SCL_LOW] <= `HIR_RST_SCL_LOW;
         reg_q[`HIR_IX_SCL_HIGH] <= `HIR_RST_SCL_HIGH;
      end
      else
      begin
         fc_q <= fc_d;
         fb_q <= fb_d;
         ptr_q <= ptr_d;
         gd_q <= gd_d;
         gv_q <= gv_d;
         reg_q <= reg_d;
      end
   end

   // --------
   // Outputs.
   // --------
   assign o_out_ready = rdy_q;
   assign o_in_valid = iv_q;
   assign o_in_byte = ib_q;
   assign o_in_last = il_q;
   assign o_eng_cmd = cmd_q;
   assign o_get_valid = gv_q;
   assign o_get_data = gd_q;
   assign o_regs = reg_q;
endmodule // hir_report_regaccess
`default_nettype wire

// ---- include/hir_cfg.svh ----
`ifndef HIR_CFG_SVH
`define HIR_CFG_SVH
// --------
// Report identifiers and layout.
// --------
`define HIR_RID_IO 8'h00
`define HIR_RID_WR 8'h3c
`define HIR_RID_PTR 8'h4b
`define HIR_RID_RD 8'h5a
`define HIR_LEN_WR 3'd5
`define HIR_LEN_PTR 3'd3
`define HIR_REP_LAST 6'd36
`define HIR_OFS_FLAGS 6'd1
`define HIR_OFS_WCNT 6'd2
`define HIR_OFS_RCNT 6'd3
`define HIR_OFS_ADDR 6'd4
`define HIR_OFS_DATA 6'd5
`define HIR_MAX_LEN 8'd32
`define HIR_RSVD_BYTE 8'h00
// --------
// Flag bit positions.
// --------
`define HIR_FL_START 0
`define HIR_FL_STOP 1
`define HIR_FL_ACKL 2
`define HIR_ST_REQERR 0
`define HIR_ST_NAK 1
`define HIR_ST_ARB 2
`define HIR_ST_TMO 3
// --------
// Timing.
// --------
`define HIR_CLK_KHZ 125000
`define HIR_FREE_MS 256
`define HIR_BYTE_MS 10
// --------
// Register addresses, indices, reset values and write masks.
// --------
`define HIR_A_SCL_LOW 16'h0341
`define HIR_A_SCL_HIGH 16'h0342
`define HIR_A_GPIO_DIR 16'h03c1
`define HIR_A_GPIO_SET 16'h03c2
`define HIR_A_GPIO_CLR 16'h03c3
`define HIR_A_GPIO_LVL 16'h03c4
`define HIR_A_GPIO_HIZ 16'h03c5
`define HIR_A_GPIO_OD 16'h03c6
`define HIR_A_GPIO_PU 16'h03c7
`define HIR_A_GPIO_PD 16'h03c8
`define HIR_A_GPIO_IRQM 16'h03c9
`define HIR_A_GPIO_IRQR 16'h03ca
`define HIR_A_PWMA_CTL 16'h03d8
`define HIR_A_PWMA_HI 16'h03d9
`define HIR_A_PWMA_LO 16'h03da
`define HIR_A_PWMB_CTL 16'h03db
`define HIR_IX_SCL_LOW 4'd0
`define HIR_IX_SCL_HIGH 4'd1
`define HIR_IX_SET 4'd3
`define HIR_IX_CLR 4'd4
`define HIR_IX_LVL 4'd5
`define HIR_RST_SCL_LOW 16'h0144
`define HIR_RST_SCL_HIGH 16'h0114
`define HIR_M_FULL 16'hffff
`define HIR_M_GPIO 16'h00ff
`define HIR_M_PWM_CTL 16'h01e7
`define HIR_M_PWM_TIME 16'h0fff
`endif

// ---- include/hir_pkg.sv ----
package hir_pkg;
   typedef enum logic [3:0] {
      ST_RX, ST_CHECK, ST_FREE, ST_WADDR, ST_WBYTE,
      ST_RADDR, ST_RBYTE, ST_STOP, ST_TX
   } hir_state_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_START_ADDR, OP_WRITE, OP_READ, OP_STOP
   } hir_eng_op_t;
   typedef struct packed {
      logic valid;
      hir_eng_op_t op;
      logic [7:0] data;
      logic ack;
   } hir_eng_cmd_t;
   typedef struct packed {
      logic done;
      logic nak;
      logic arb_lost;
      logic [7:0] rdata;
   } hir_eng_rsp_t;
   typedef logic [15:0][15:0] hir_regs_t;
   typedef logic [31:0][7:0] hir_buf_t;
endpackage

// ---- test/hir_eng_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------
// Byte engine stand-in.
// --------
module hir_eng_model (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Engine side.
   input wire hir_pkg::hir_eng_cmd_t i_cmd,
   output hir_pkg::hir_eng_rsp_t o_rsp,
   // Faults and timing.
   input wire logic [3:0] i_lat,
   input wire logic i_stall,
   input wire logic [15:0] i_nak_at,
   input wire logic [15:0] i_arb_at,
   // Observation.
   output logic [15:0] o_n_cmd,
   output logic [7:0] o_last_addr
);
   logic busy_q;
   logic [3:0] cnt_q;
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         o_rsp <= '0;
         o_n_cmd <= 16'h0;
         o_last_addr <= 8'h0;
      end
      else
      begin
         o_rsp.done <= 1'b0;
         o_rsp.nak <= 1'b0;
         o_rsp.arb_lost <= 1'b0;
         o_rsp.rdata <= ~o_rsp.rdata;
         if (!i_cmd.valid)
            busy_q <= 1'b0;
         else if (!busy_q && !o_rsp.done)
         begin
            busy_q <= 1'b1;
            cnt_q <= i_lat;
         end
         else if (busy_q && !i_stall && cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
         else if (busy_q && !i_stall)
         begin
            busy_q <= 1'b0;
            o_rsp.done <= 1'b1;
            o_rsp.nak <= (o_n_cmd == i_nak_at);
            o_rsp.arb_lost <= (o_n_cmd == i_arb_at);
            o_rsp.rdata <= 8'ha0 + o_n_cmd[7:0];
            o_n_cmd <= o_n_cmd + 16'h1;
            if (i_cmd.op == hir_pkg::OP_START_ADDR)
               o_last_addr <= i_cmd.data;
         end
      end
   end
endmodule // hir_eng_model
`default_nettype wire

// ---- test/hir_report_regaccess_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------
// Response stream and feature checks.
// --------
module hir_report_regaccess_chk (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Streams.
   input wire logic i_out_valid,
   input wire logic [7:0] i_out_byte,
   input wire logic o_out_ready,
   input wire logic o_in_valid,
   input wire logic [7:0] o_in_byte,
   input wire logic o_in_last,
   input wire logic i_in_ready,
   // Feature read.
   input wire logic i_get_req,
   input wire logic [7:0] i_get_id,
   input wire logic o_get_valid
);
   logic [5:0] ridx_q, ridx_d, qidx_q, qidx_d;
   logic [3:0] seq_q, seq_d;
   logic bad_q, bad_d;
   always_comb
   begin
      ridx_d = ridx_q;
      qidx_d = qidx_q;
      seq_d = seq_q;
      bad_d = bad_q;
      if (o_in_valid && i_in_ready)
         ridx_d = o_in_last ? 6'h00 : ridx_q + 6'h01;
      if (i_out_valid && o_out_ready)
      begin
         qidx_d = (qidx_q == 6'h24) ? 6'h00 : qidx_q + 6'h01;
         if (qidx_q == 6'h00)
            bad_d = (i_out_byte != 8'h00);
         if (qidx_q == 6'h01)
            seq_d = i_out_byte[7:4];
         if (qidx_q == 6'h02 || qidx_q == 6'h03)
            bad_d = bad_q | (i_out_byte > 8'h20);
      end
   end
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ridx_q <= 6'h00;
         qidx_q <= 6'h00;
         seq_q <= 4'h0;
         bad_q <= 1'b0;
      end
      else
      begin
         ridx_q <= ridx_d;
         qidx_q <= qidx_d;
         seq_q <= seq_d;
         bad_q <= bad_d;
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   chk_rsp_id_zero: assert property (o_in_valid && ridx_q == 6'h00 |-> o_in_byte == 8'h00)
      else $error("bad id");
   chk_last_at_end: assert property (o_in_valid && o_in_last |-> ridx_q == 6'h24)
      else $error("last misplaced");
   chk_bad_flag: assert property (o_in_valid && ridx_q == 6'h01 |-> o_in_byte[0] == bad_q)
      else $error("bad error flag");
   chk_bad_counts: assert property (o_in_valid && bad_q && (ridx_q == 6'h02 || ridx_q == 6'h03)
         |-> o_in_byte == 8'h00)
      else $error("refused counts");
   chk_seq_echo: assert property (o_in_valid && ridx_q == 6'h01 |-> o_in_byte[7:4] == seq_q)
      else $error("bad sequence");
   chk_count_range: assert property (o_in_valid && (ridx_q == 6'h02 || ridx_q == 6'h03)
         |-> o_in_byte <= 8'h20)
      else $error("count too big");
   chk_rsvd_zero: assert property (o_in_valid && ridx_q == 6'h04 |-> o_in_byte == 8'h00)
      else $error("bad reserved");
   chk_byte_hold: assert property (o_in_valid && !i_in_ready
         |=> o_in_valid && $stable(o_in_byte))
      else $error("byte not held");
   chk_one_reply: assert property (o_in_valid |-> !o_out_ready)
      else $error("request overlap");
   chk_get_answer: assert property (i_get_req && i_get_id == 8'h5a |=> o_get_valid)
      else $error("read unanswered");
   chk_get_quiet: assert property (!(i_get_req && i_get_id == 8'h5a) |=> !o_get_valid)
      else $error("read unasked");
endmodule // hir_report_regaccess_chk
bind hir_report_regaccess hir_report_regaccess_chk i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_out_valid(i_out_valid), .i_out_byte(i_out_byte), .o_out_ready(o_out_ready),
   .o_in_valid(o_in_valid), .o_in_byte(o_in_byte), .o_in_last(o_in_last),
   .i_in_ready(i_in_ready), .i_get_req(i_get_req), .i_get_id(i_get_id),
   .o_get_valid(o_get_valid));
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------
// Self-checking bench.
// --------
module testbench;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, i_out_valid = 1'b0, i_in_ready = 1'b1;
   logic i_bus_free = 1'b1, i_feat_valid = 1'b0, i_feat_end = 1'b0, i_get_req = 1'b0;
   logic [7:0] i_out_byte = 8'h00, i_feat_byte = 8'h00, i_get_id = 8'h00, o_in_byte;
   logic o_out_ready, o_in_valid, o_in_last, o_get_valid, stall = 1'b0;
   logic [15:0] o_get_data, nak_at = 16'hffff, arb_at = 16'hffff, n_cmd;
   logic [3:0] lat = 4'h1;
   logic [7:0] last_addr;
   logic [15:0] rsp [37];
   hir_pkg::hir_eng_cmd_t eng_cmd;
   hir_pkg::hir_eng_rsp_t eng_rsp;
   hir_pkg::hir_regs_t o_regs;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   hir_report_regaccess #(.FREE_CYC(40), .BYTE_CYC(20)) i_dut (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_out_valid(i_out_valid), .i_out_byte(i_out_byte),
      .o_out_ready(o_out_ready), .o_in_valid(o_in_valid), .o_in_byte(o_in_byte),
      .o_in_last(o_in_last), .i_in_ready(i_in_ready), .o_eng_cmd(eng_cmd),
      .i_eng_rsp(eng_rsp), .i_bus_free(i_bus_free), .i_feat_valid(i_feat_valid),
      .i_feat_byte(i_feat_byte), .i_feat_end(i_feat_end), .i_get_req(i_get_req),
      .i_get_id(i_get_id), .o_get_valid(o_get_valid), .o_get_data(o_get_data),
      .o_regs(o_regs));
   hir_eng_model i_eng (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(eng_cmd), .o_rsp(eng_rsp),
      .i_lat(lat), .i_stall(stall), .i_nak_at(nak_at), .i_arb_at(arb_at), .o_n_cmd(n_cmd),
      .o_last_addr(last_addr));
   always #4 i_mclk = ~i_mclk;
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // --------
   // Feature and request drivers.
   // --------
   task automatic fb(input logic [7:0] b, input logic e);
      @(negedge i_mclk);
      i_feat_valid = !e;
      i_feat_end = e;
      i_feat_byte = b;
      @(negedge i_mclk);
      i_feat_valid = 1'b0;
      i_feat_end = 1'b0;
   endtask
   task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
      fb(8'h3c, 1'b0);
      fb(a[7:0], 1'b0);
      fb(a[15:8], 1'b0);
      fb(d[7:0], 1'b0);
      fb(d[15:8], 1'b0);
      fb(8'h00, 1'b1);
   endtask
   task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
      fb(8'h4b, 1'b0);
      fb(a[7:0], 1'b0);
      fb(a[15:8], 1'b0);
      fb(8'h00, 1'b1);
      i_get_req = 1'b1;
      i_get_id = 8'h5a;
      @(negedge i_mclk);
      i_get_req = 1'b0;
      chk("get valid", 16'h0001, 16'(o_get_valid));
      chk("get data", e, o_get_data);
   endtask
   task automatic req(input logic [7:0] id, fl, wc, rc, ta);
      logic rdy;
      for (int k = 0; k < 37; k++)
      begin
         @(negedge i_mclk);
         i_out_valid = 1'b1;
         i_out_byte = k == 0 ? id : k == 1 ? fl : k == 2 ? wc : k == 3 ? rc : k == 4 ? ta : 8'(k);
         rdy = 1'b0;
         while (!rdy)
         begin
            rdy = (o_out_ready === 1'b1);
            @(posedge i_mclk);
         end
      end
      @(negedge i_mclk);
      i_out_valid = 1'b0;
      i_in_ready = 1'b0;
      repeat (3) @(negedge i_mclk);
      i_in_ready = 1'b1;
      for (int k = 0; k < 37; k++)
      begin
         while (o_in_valid !== 1'b1)
            @(negedge i_mclk);
         rsp[k] = 16'(o_in_byte);
         @(negedge i_mclk);
      end
   endtask
   // --------
   // Scenarios.
   // --------
   task automatic t_regs();
      reg_rd(16'h0341, 16'h0144);
      reg_rd(16'h0342, 16'h0114);
      reg_wr(16'h0341, 16'hbeef);
      reg_rd(16'h0341, 16'hbeef);
      reg_wr(16'h03c1, 16'hffff);
      reg_rd(16'h03c1, 16'h00ff);
      reg_wr(16'h0400, 16'h5555);
      reg_rd(16'h0400, 16'h0000);
      reg_wr(16'h03c2, 16'h00f0);
      chk("level", 16'h00f0, o_regs[5]);
      reg_wr(16'h03c3, 16'h0030);
      chk("level", 16'h00c0, o_regs[5]);
      reg_rd(16'h03c2, 16'h0000);
      $display("register test done");
   endtask
   task automatic t_bad();
      logic [15:0] n0;
      logic [7:0] tb [3][3] = '{'{8'h00, 8'h21, 8'h00}, '{8'h07, 8'h01, 8'h00},
         '{8'h00, 8'h00, 8'h21}};
      for (int k = 0; k < 3; k++)
      begin
         n0 = n_cmd;
         req(tb[k][0], 8'h53, tb[k][1], tb[k][2], 8'h20);
         chk("status", 16'h0051, rsp[1]);
         chk("written", 16'h0000, rsp[2]);
         chk("commands", n0, n_cmd);
      end
      $display("refusal test done");
   endtask
   task automatic t_xfer();
      logic [15:0] n0;
      n0 = n_cmd;
      lat = 4'h3;
      req(8'h00, 8'ha3, 8'h02, 8'h03, 8'h6a);
      chk("id", 16'h0000, rsp[0]);
      chk("status", 16'h00a0, rsp[1]);
      chk("written", 16'h0002, rsp[2]);
      chk("read", 16'h0003, rsp[3]);
      chk("reserved", 16'h0000, rsp[4]);
      for (int k = 0; k < 3; k++)
         chk("data", 16'(8'ha4 + n0[7:0] + 8'(k)), rsp[5 + k]);
      chk("commands", n0 + 16'h8, n_cmd);
      chk("address", 16'h006b, 16'(last_addr));
      n0 = n_cmd;
      lat = 4'h0;
      req(8'h00, 8'h33, 8'h20, 8'h00, 8'h6b);
      chk("status", 16'h0030, rsp[1]);
      chk("written", 16'h0020, rsp[2]);
      chk("read", 16'h0000, rsp[3]);
      chk("commands", n0 + 16'h22, n_cmd);
      chk("address", 16'h006a, 16'(last_addr));
      $display("transfer test done");
   endtask
   task automatic t_fault();
      logic [15:0] n0;
      lat = 4'h1;
      n0 = n_cmd;
      nak_at = n_cmd + 16'h1;
      req(8'h00, 8'h03, 8'h02, 8'h00, 8'h50);
      nak_at = 16'hffff;
      chk("status", 16'h0002, rsp[1]);
      chk("commands", n0 + 16'h3, n_cmd);
      n0 = n_cmd;
      arb_at = n_cmd;
      req(8'h00, 8'h13, 8'h01, 8'h01, 8'h50);
      arb_at = 16'hffff;
      chk("status", 16'h0014, rsp[1]);
      chk("commands", n0 + 16'h1, n_cmd);
      stall = 1'b1;
      req(8'h00, 8'h23, 8'h01, 8'h00, 8'h50);
      stall = 1'b0;
      chk("status", 16'h0028, rsp[1]);
      n0 = n_cmd;
      i_bus_free = 1'b0;
      req(8'h00, 8'h41, 8'h01, 8'h00, 8'h50);
      i_bus_free = 1'b1;
      chk("status", 16'h0048, rsp[1]);
      chk("commands", n0, n_cmd);
      $display("fault test done");
   endtask
   initial
   begin
      repeat (4) @(negedge i_mclk);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_mclk);
      t_regs();
      t_bad();
      t_xfer();
      t_fault();
      stop_test();
   end
endmodule // testbench
`default_nettype wire
